// File: pwm16_defs.svh
// Constants of the 16-bit fast and dual-slope PWM timer.
// Functional notes
// [RL1] Fast mode counts to top, then clears.
// [RL2] Fast mode sets overflow, top flag at top.
// [RL3] Compare flag set when count equals compare.
// [RL4] Fixed top masks high bits of compare writes.
// [RL5] Capture top written directly; overshoot wraps.
// [RL6] Fast mode loads compare buffers at top.
// [RL7] Output mode 2 non-inverted, 3 inverted.
// [RL8] Fast output flips on match, restores at wrap.
// [RL9] Pin driven only when direction bit set.
// [RL10] Compare zero spikes; compare top holds constant.
// [RL11] Mode 15 channel A toggle option.
// [RL12] Timer tick prescaled by 1/8/64/256/1024.
// [RL13] Dual slope: up clears, down sets.
// [RL14] Dual slope top choices; reverse after top.
// [RL15] Dual slope overflow at bottom, top flag.
// [RL16] Dual slope loads buffers only at top.
// [RL17] Software keeps register top at least 3.
// [RL18] Software keeps top above all compares.
// [RL19] Software prefers other mode for changing top.
// [RL20] Dual slope extremes give constant levels.
// [RL21] Mode 11 channel A toggle option.
// [RL22] Everything moves only on timer tick; outside the PWM modes the compares load every clock.
`ifndef PWM16_DEFS_SVH
`define PWM16_DEFS_SVH

`define PWM16_ADDR_CTRL 8'h00
`define PWM16_ADDR_STATUS 8'h04
`define PWM16_ADDR_COUNT 8'h08
`define PWM16_ADDR_CMPA 8'h0C
`define PWM16_ADDR_CMPB 8'h10
`define PWM16_ADDR_CMPC 8'h14
`define PWM16_ADDR_CAPTOP 8'h18

`define PWM16_CTRL_MODE_LSB 0
`define PWM16_CTRL_CS_LSB 4
`define PWM16_CTRL_COM_LSB 8
`define PWM16_CTRL_DIR_LSB 16
`define PWM16_CTRL_RESET 32'h0000_0000

`define PWM16_ST_OVF 0
`define PWM16_ST_CAP 1
`define PWM16_ST_CMP_LSB 2

`define PWM16_MODE_PC8 4'h1
`define PWM16_MODE_PC9 4'h2
`define PWM16_MODE_PC10 4'h3
`define PWM16_MODE_FAST8 4'h5
`define PWM16_MODE_FAST9 4'h6
`define PWM16_MODE_FAST10 4'h7
`define PWM16_MODE_PCCAP 4'hA
`define PWM16_MODE_PCA 4'hB
`define PWM16_MODE_FASTCAP 4'hE
`define PWM16_MODE_FASTA 4'hF

`define PWM16_TOP8 16'h00FF
`define PWM16_TOP9 16'h01FF
`define PWM16_TOP10 16'h03FF
`define PWM16_MAX 16'hFFFF
`define PWM16_BOTTOM 16'h0000

`define PWM16_COM_TOGGLE 2'h1
`define PWM16_COM_NONINV 2'h2
`define PWM16_COM_INV 2'h3

`define PWM16_CS_STOP 3'h0
`define PWM16_CS_DIV1 3'h1
`define PWM16_CS_DIV8 3'h2
`define PWM16_CS_DIV64 3'h3
`define PWM16_CS_DIV256 3'h4
`define PWM16_CS_DIV1024 3'h5
`define PWM16_MASK_DIV1 10'h000
`define PWM16_MASK_DIV8 10'h007
`define PWM16_MASK_DIV64 10'h03F
`define PWM16_MASK_DIV256 10'h0FF
`define PWM16_MASK_DIV1024 10'h3FF

`endif

// File: pwm16_pkg.sv
// Types shared by the PWM timer modules.
package pwm16_pkg;
  typedef enum logic {PWM16_UP, PWM16_DOWN} pwm16_dir_t;
  typedef struct packed {
    logic tick;
    logic fast;
    logic pc;
    logic up;
    logic atTop;
  } pwm16_evt_t;
endpackage

// File: pwm16_prescaler.sv
// Timer tick divider for the PWM timer.
`timescale 1ns/100ps
`include "pwm16_defs.svh"
module pwm16_prescaler import pwm16_pkg::*; #(
  parameter int PRE_W = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Divider select and tick.
  input wire logic [2:0] clkSel,
  output logic tick
);
  logic [PRE_W-1:0] divCnt;
  logic [9:0] mask;

  generate
    if (PRE_W < 10) begin : g_chk
      $error("Prescaler needs at least ten bits.");
    end
  endgenerate

  always_comb begin
    unique case (clkSel)
      `PWM16_CS_DIV1: mask = `PWM16_MASK_DIV1;
      `PWM16_CS_DIV8: mask = `PWM16_MASK_DIV8;
      `PWM16_CS_DIV64: mask = `PWM16_MASK_DIV64;
      `PWM16_CS_DIV256: mask = `PWM16_MASK_DIV256;
      `PWM16_CS_DIV1024: mask = `PWM16_MASK_DIV1024;
      default: mask = `PWM16_MASK_DIV1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + 1'b1;
    end
  end

  // A stopped timer gives no tick at all.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (clkSel != `PWM16_CS_STOP) &&
        ((divCnt[9:0] & mask) == mask); // RL12
    end
  end
endmodule

// File: pwm16_channel.sv
// Waveform level of one compare output channel.
`timescale 1ns/100ps
`include "pwm16_defs.svh"
module pwm16_channel import pwm16_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Counter events and compare state.
  input wire pwm16_evt_t evt,
  input wire logic match,
  input wire logic cmpZero,
  input wire logic cmpTop,
  input wire logic [1:0] outMode,
  input wire logic toggleOk,
  // Waveform level.
  output logic level
);
  logic inv;
  assign inv = (outMode == `PWM16_COM_INV); // RL7

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (evt.tick) begin // RL22
      if (outMode == `PWM16_COM_NONINV || outMode == `PWM16_COM_INV) begin
        if (evt.fast) begin
          // The wrap wins over a match so compare equal to top holds.
          if (evt.atTop) begin
            level <= ~inv; // RL8 RL10
          end else if (match) begin
            level <= inv; // RL8
          end
        end else if (evt.pc) begin
          if (cmpZero) begin
            level <= inv; // RL20
          end else if (cmpTop) begin
            level <= ~inv; // RL20
          end else if (match) begin
            level <= evt.up ? inv : ~inv; // RL13
          end
        end
      end else if (outMode == `PWM16_COM_TOGGLE && toggleOk && match) begin
        level <= ~level; // RL11 RL21
      end
    end
  end
endmodule

// File: pwm16_top.sv
// Sixteen-bit timer with fast and dual-slope PWM, APB registers.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "pwm16_defs.svh"
module pwm16_top import pwm16_pkg::*; #(
  parameter int NUM_CH = 3,
  parameter int PRE_W = 10
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Compare output pins.
  output logic [NUM_CH-1:0] chanOut,
  output logic [NUM_CH-1:0] chanOe
);
  logic [1:0] rstSync;
  logic rst_n;
  logic [31:0] ctrl;
  logic [NUM_CH+1:0] status;
  logic [15:0] counterValue;
  logic [15:0] captureTopValue;
  logic [15:0] cmpBuf [NUM_CH];
  logic [15:0] cmpAct [NUM_CH];
  pwm16_dir_t dir;
  logic tick;
  logic [3:0] mode;
  logic fast;
  logic pc;
  logic [15:0] top;
  logic atTop;
  logic atBottom;
  logic loadNow;
  logic setOvf;
  logic setCap;
  logic [NUM_CH-1:0] setCmp;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] level;
  logic busDone;
  logic busWr;
  logic [31:0] readMux;
  logic mapped;
  pwm16_evt_t evt;

  generate
    if (NUM_CH < 1 || NUM_CH > 3) begin : g_chk
      $error("Channel count must be one to three.");
    end
  endgenerate

  function automatic logic isFast(input logic [3:0] m);
    return m == `PWM16_MODE_FAST8 || m == `PWM16_MODE_FAST9 ||
      m == `PWM16_MODE_FAST10 || m == `PWM16_MODE_FASTCAP ||
      m == `PWM16_MODE_FASTA;
  endfunction

  function automatic logic isPc(input logic [3:0] m);
    return m == `PWM16_MODE_PC8 || m == `PWM16_MODE_PC9 ||
      m == `PWM16_MODE_PC10 || m == `PWM16_MODE_PCCAP ||
      m == `PWM16_MODE_PCA;
  endfunction

  function automatic logic [15:0] fixedMask(input logic [3:0] m);
    case (m)
      `PWM16_MODE_PC8, `PWM16_MODE_FAST8: fixedMask = `PWM16_TOP8;
      `PWM16_MODE_PC9, `PWM16_MODE_FAST9: fixedMask = `PWM16_TOP9;
      `PWM16_MODE_PC10, `PWM16_MODE_FAST10: fixedMask = `PWM16_TOP10;
      default: fixedMask = `PWM16_MAX;
    endcase
  endfunction

  // Reset release through two flops.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rst_n = rstSync[1];

  assign mode = ctrl[`PWM16_CTRL_MODE_LSB +: 4];
  assign fast = isFast(mode);
  assign pc = isPc(mode);

  // Top selection for both PWM families.
  always_comb begin
    case (mode)
      `PWM16_MODE_FASTCAP, `PWM16_MODE_PCCAP: top = captureTopValue;
      `PWM16_MODE_FASTA, `PWM16_MODE_PCA: top = cmpAct[0];
      default: top = fixedMask(mode); // RL1 RL14
    endcase
  end

  assign atTop = (counterValue == top) && (fast || (pc && dir == PWM16_UP));
  assign atBottom = pc && dir == PWM16_DOWN &&
    counterValue == `PWM16_BOTTOM;
  // Outside the PWM modes compares load straight through.
  assign loadNow = (fast || pc) ? (tick && atTop) : 1'b1; // RL6 RL16
  assign setOvf = tick && (fast ? atTop :
    pc ? atBottom : counterValue == `PWM16_MAX); // RL2 RL15
  assign setCap = tick && atTop && (mode == `PWM16_MODE_FASTCAP ||
    mode == `PWM16_MODE_PCCAP); // RL2 RL15

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      match[i] = counterValue == cmpAct[i];
      setCmp[i] = tick && match[i]; // RL3
    end
    if (tick && atTop && (mode == `PWM16_MODE_FASTA ||
        mode == `PWM16_MODE_PCA)) begin
      setCmp[0] = 1'b1; // RL2 RL15
    end
  end

  // Counter: single slope wraps at top, dual slope turns at the ends.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counterValue <= `PWM16_BOTTOM;
      dir <= PWM16_UP;
    end else if (tick) begin // RL22
      if (fast && atTop) begin
        counterValue <= `PWM16_BOTTOM; // RL1
      end else if (pc) begin
        unique case (dir)
          PWM16_UP: begin
            if (atTop) begin
              dir <= PWM16_DOWN; // RL13 RL14
              counterValue <= counterValue - 1'b1;
            end else begin
              counterValue <= counterValue + 1'b1;
            end
          end
          PWM16_DOWN: begin
            if (atBottom) begin
              dir <= PWM16_UP; // RL13
              counterValue <= counterValue + 1'b1;
            end else begin
              counterValue <= counterValue - 1'b1;
            end
          end
        endcase
      end else begin
        // A top below the count runs on through the wrap.
        counterValue <= counterValue + 1'b1; // RL5
        dir <= PWM16_UP;
      end
    end
  end

  // APB: answer on the second access cycle.
  assign busDone = psel && penable && pready;
  assign busWr = busDone && pwrite;

  always_comb begin
    mapped = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      `PWM16_ADDR_CTRL: readMux = ctrl;
      `PWM16_ADDR_STATUS: readMux[NUM_CH+1:0] = status;
      `PWM16_ADDR_COUNT: readMux[15:0] = counterValue;
      `PWM16_ADDR_CAPTOP: readMux[15:0] = captureTopValue;
      `PWM16_ADDR_CMPA: readMux[15:0] = cmpBuf[0];
      `PWM16_ADDR_CMPB: begin
        if (NUM_CH > 1) readMux[15:0] = cmpBuf[NUM_CH > 1 ? 1 : 0];
        else mapped = 1'b0;
      end
      `PWM16_ADDR_CMPC: begin
        if (NUM_CH > 2) readMux[15:0] = cmpBuf[NUM_CH > 2 ? 2 : 0];
        else mapped = 1'b0;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : readMux;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `PWM16_CTRL_RESET;
    end else if (busWr && paddr == `PWM16_ADDR_CTRL) begin
      ctrl <= pwdata;
    end
  end

  // Flags are cleared by writing ones; a new event wins the clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~((busWr && paddr == `PWM16_ADDR_STATUS) ?
        pwdata[NUM_CH+1:0] : '0)) | {setCmp, setCap, setOvf};
    end
  end

  // Capture top has no buffer, so a late low write costs a full wrap.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      captureTopValue <= `PWM16_BOTTOM;
    end else if (busWr && paddr == `PWM16_ADDR_CAPTOP) begin
      captureTopValue <= pwdata[15:0]; // RL5
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [7:0] addr;
    assign addr = `PWM16_ADDR_CMPA + 8'(4 * g);

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cmpBuf[g] <= `PWM16_BOTTOM;
      end else if (busWr && paddr == addr) begin
        cmpBuf[g] <= pwdata[15:0] & fixedMask(mode); // RL4 RL6
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cmpAct[g] <= `PWM16_BOTTOM;
      end else if (loadNow) begin
        cmpAct[g] <= cmpBuf[g]; // RL6 RL16
      end
    end

    pwm16_channel u_ch (
      .clk(ref_clk),
      .rst_n(rst_n),
      .evt(evt),
      .match(match[g]),
      .cmpZero(cmpAct[g] == `PWM16_BOTTOM),
      .cmpTop(cmpAct[g] == top),
      .outMode(ctrl[`PWM16_CTRL_COM_LSB + 2 * g +: 2]),
      .toggleOk(g == 0 && (mode == `PWM16_MODE_FASTA ||
        mode == `PWM16_MODE_PCA)),
      .level(level[g])
    );

    // The pin follows the level one clock later, gated by direction.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        chanOut[g] <= 1'b0;
        chanOe[g] <= 1'b0;
      end else begin
        chanOe[g] <= ctrl[`PWM16_CTRL_DIR_LSB + g];
        chanOut[g] <= ctrl[`PWM16_CTRL_DIR_LSB + g] & level[g]; // RL9
      end
    end
  end

  assign evt = '{tick: tick, fast: fast, pc: pc,
    up: dir == PWM16_UP, atTop: atTop};

  pwm16_prescaler #(
    .PRE_W(PRE_W)
  ) u_pre (
    .clk(ref_clk),
    .rst_n(rst_n),
    .clkSel(ctrl[`PWM16_CTRL_CS_LSB +: 3]),
    .tick(tick)
  );

  a_fast_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && fast && atTop |=> counterValue == `PWM16_BOTTOM) // RL1
    else $error("Fast mode counter did not clear after top.");
  a_fast_ovf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && fast && atTop |=> status[`PWM16_ST_OVF]) // RL2
    else $error("Overflow flag missing at fast top.");
  a_match_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && counterValue == cmpAct[0] |=> status[`PWM16_ST_CMP_LSB]) // RL3
    else $error("Compare flag missing on match.");
  a_fixed_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busWr && paddr == `PWM16_ADDR_CMPA && mode == `PWM16_MODE_FAST8
    |=> cmpBuf[0][15:8] == 8'h00) // RL4
    else $error("Compare write not masked to eight bits.");
  a_cap_direct: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busWr && paddr == `PWM16_ADDR_CAPTOP
    |=> captureTopValue == $past(pwdata[15:0])) // RL5
    else $error("Capture top not written at once.");
  a_buf_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && fast && atTop |=> cmpAct[0] == $past(cmpBuf[0])) // RL6
    else $error("Compare buffer not loaded at top.");
  a_pin_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !chanOe[0] |-> !chanOut[0]) // RL9
    else $error("Pin driven while direction is input.");
  a_pc_turn: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && pc && atTop ##1 !tick [*2] |-> dir == PWM16_DOWN &&
    counterValue == $past(top, 2) - 16'h0001) // RL14
    else $error("Dual slope did not turn after top.");
  a_pc_ovf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && atBottom |=> status[`PWM16_ST_OVF] && dir == PWM16_UP) // RL15
    else $error("Overflow flag missing at bottom.");
  a_tick_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !tick && !$past(!rst_n) |=> $stable(counterValue) &&
    $stable(level)) // RL22
    else $error("Counter moved without a timer tick.");
  a_cap_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && atTop && mode == `PWM16_MODE_FASTCAP
    |=> status[`PWM16_ST_CAP]) // RL2
    else $error("Capture flag missing at top.");
  a_pc_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && pc && atTop |=> cmpAct[0] == $past(cmpBuf[0])) // RL16
    else $error("Dual slope buffer not loaded at top.");
  a_buf_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fast || pc) && !(tick && atTop) |=> $stable(cmpAct[0])) // RL6 RL16
    else $error("Active compare changed away from top.");
  a_pin_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> chanOut[0] ==
    $past(ctrl[`PWM16_CTRL_DIR_LSB] && level[0])) // RL9
    else $error("Pin does not follow the gated level.");

  c_fast_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    tick && fast && atTop);
  c_pc_turn: cover property (@(posedge ref_clk) disable iff (!rst_n)
    tick && pc && atTop ##[1:300] tick && atBottom);
  c_toggle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    tick && mode == `PWM16_MODE_FASTA && match[0] &&
    ctrl[`PWM16_CTRL_COM_LSB +: 2] == `PWM16_COM_TOGGLE);
  c_pc_toggle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    tick && mode == `PWM16_MODE_PCA && match[0] &&
    ctrl[`PWM16_CTRL_COM_LSB +: 2] == `PWM16_COM_TOGGLE);
endmodule

// File: pwm16_load.sv
// Load on one PWM pin that measures period and high time of the wave.
`timescale 1ns/100ps
module pwm16_load (
  // Clock.
  input wire logic clk,
  // Pin driver.
  input wire logic pin,
  input wire logic oe,
  // Cycles between the last two rising edges, high cycles among them.
  output int period,
  output int highTime,
  output int edges
);
  logic node;
  logic last = 1'h0;
  int cnt = 0;
  int hi = 0;
  int perSeen = 0;
  int hiSeen = 0;
  int nEdge = 0;
  // The load has a pull-down, so an undriven pin reads low.
  assign node = oe ? pin : 1'h0;
  assign period = perSeen;
  assign highTime = hiSeen;
  assign edges = nEdge;
  always @(posedge clk) begin
    if (node === 1'h1 && last !== 1'h1) begin
      perSeen <= cnt;
      hiSeen <= hi;
      nEdge <= nEdge + 1;
      cnt <= 1;
      hi <= 1;
    end else begin
      cnt <= cnt + 1;
      hi <= hi + int'(node === 1'h1);
    end
    last <= node;
  end
endmodule

// File: pwm16_bench.sv
// Self-checking bench for the PWM timer with a load on every pin.
`timescale 1ns/100ps
`include "pwm16_defs.svh"
module pwm16_bench import pwm16_pkg::*;;
  typedef struct {int m; int cs; int com; int top; int cmp;} pwm16_row_t;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready;
  logic pslverr;
  logic rerr;
  logic [2:0] chanOut;
  logic [2:0] chanOe;
  logic [31:0] seed = 32'hD4FA;
  int failures = 0;
  int n_tests = 0;
  int period[3];
  int highTime[3];
  int edges[3];
  int fac[6] = '{0, 1, 8, 64, 256, 1024};
  int cm[5] = '{14, 14, 10, 10, 10};
  int cc[5] = '{2, 3, 2, 3, 2};
  int cv[5] = '{5, 5, 0, 0, 5};
  // Tops stay at 3 or more and compares never exceed top.
  pwm16_row_t rows[12] = '{'{5, 1, 2, 255, -1}, '{6, 1, 3, 511, -1},
    '{7, 1, 2, 1023, -1}, '{1, 1, 3, 255, -1}, '{2, 1, 2, 511, -1},
    '{3, 1, 2, 1023, -1}, '{14, 2, 2, 9, 0}, '{10, 3, 3, 5, -1},
    '{15, 1, 1, 3, -1}, '{11, 1, 1, 6, -1}, '{14, 4, 3, 3, -1},
    '{14, 5, 2, 3, -1}};

  pwm16_top #(.NUM_CH(3), .PRE_W(10)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanOut(chanOut), .chanOe(chanOe));
  for (genvar i = 0; i < 3; i++) begin : g_load
    pwm16_load load (.clk(ref_clk), .pin(chanOut[i]), .oe(chanOe[i]),
      .period(period[i]), .highTime(highTime[i]), .edges(edges[i]));
  end

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %0s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      failures++;
      wrap_up();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  // Reset first so a stale count can never overshoot a small top.
  task automatic setup(input int m, cs, comA, comB, top, cmp);
    arst_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    wr(`PWM16_ADDR_CAPTOP, top);
    wr(`PWM16_ADDR_CMPA, comA == 1 ? top : cmp);
    wr(`PWM16_ADDR_CMPB, cmp);
    wr(`PWM16_ADDR_CMPC, cmp);
    wr(`PWM16_ADDR_CTRL, m | cs << 4 | comA << 8 | comB << 10 | comB << 12
       | 32'h7 << 16);
  endtask

  task automatic measure(input int ch, input int per, input int hi);
    int e0;
    int k;
    e0 = edges[ch];
    k = 0;
    while (edges[ch] < e0 + 3 && k < 40000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 40000) begin
      failures++;
      wrap_up();
    end
    chk("period", per, period[ch]);
    chk("high time", hi, highTime[ch]);
  endtask

  // Reads the count over and over; every change must be the next step.
  task automatic seq(input int m);
    int c;
    int up;
    int e;
    int n;
    setup(m, 3, 1, 2, 5, 2);
    c = 0;
    up = 1;
    n = 0;
    for (int k = 0; k < 600 && n < 24; k++) begin
      rd(`PWM16_ADDR_COUNT);
      if (rdat !== 32'(c)) begin
        if (m == 15) begin
          e = c == 5 ? 0 : c + 1;
        end else begin
          if (c == 5) up = 0;
          if (c == 0) up = 1;
          e = up ? c + 1 : c - 1;
        end
        chk("count step", e, rdat);
        c = int'(rdat);
        n++;
      end
    end
  endtask

  initial begin
    pwm16_row_t r;
    int cmp;
    int per;
    int hi;
    int c;
    logic tog;
    logic dual;
    setup(0, 0, 0, 0, 0, 0);
    wr(`PWM16_ADDR_CTRL, 32'h0);
    rd(`PWM16_ADDR_CTRL);
    chk("control", 32'h0, rdat);
    rd(8'h1C);
    chk("unmapped error", 32'h1, 32'(rerr));
    chk("unmapped data", 32'h0, rdat);
    wr(`PWM16_ADDR_COUNT, 32'h55);
    rd(`PWM16_ADDR_COUNT);
    chk("count", 32'h0, rdat);
    for (int i = 0; i < 6; i++) begin
      wr(`PWM16_ADDR_CTRL, rows[i].m);
      wr(`PWM16_ADDR_CMPA, 32'hFFFF);
      rd(`PWM16_ADDR_CMPA);
      chk("masked compare", rows[i].top, rdat);
    end
    $display("test registers done");
    seq(15);
    seq(10);
    $display("test count sequence done");
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      cmp = r.cmp >= 0 ? r.cmp : 1 + int'(rnd() % 32'(r.top - 1));
      tog = r.com == 1;
      dual = r.m < 5 || r.m == 10 || r.m == 11;
      per = dual ? 2 * r.top : r.top + 1;
      hi = dual ? 2 * cmp : cmp + 1;
      if (tog) begin
        per = 2 * per;
        hi = per / 2;
      end else if (r.com == 3) begin
        hi = per - hi;
      end
      setup(r.m, r.cs, tog ? 1 : r.com, tog ? 2 : r.com, r.top, cmp);
      measure(tog ? 0 : 1, fac[r.cs] * per, fac[r.cs] * hi);
    end
    $display("test waveforms done");
    for (int i = 0; i < 5; i++) begin
      setup(cm[i], 1, cc[i], cc[i], 5, cv[i]);
      repeat (100) @(posedge ref_clk);
      for (int j = 0; j < 24; j++) begin
        @(posedge ref_clk);
        chk("steady level", 32'((cv[i] != 0) ^ (cc[i] == 3)), 32'(chanOut[1]));
      end
    end
    // Still running with a high level, but every pin set as input.
    wr(`PWM16_ADDR_CTRL, 32'h0000_2A1A);
    repeat (4) @(posedge ref_clk);
    chk("pin enable", 32'h0, 32'(chanOe));
    chk("pin level", 32'h0, 32'(chanOut));
    $display("test extremes done");
    for (int i = 0; i < 2; i++) begin
      setup(i ? 11 : 14, 1, 1, 2, 6, 3);
      repeat (60) @(posedge ref_clk);
      wr(`PWM16_ADDR_CTRL, i ? 11 : 14);
      rd(`PWM16_ADDR_STATUS);
      chk("flags", i ? 32'h1D : 32'h1F, rdat);
      wr(`PWM16_ADDR_STATUS, 32'h1F);
      rd(`PWM16_ADDR_STATUS);
      chk("flags cleared", 32'h0, rdat);
      rd(`PWM16_ADDR_COUNT);
      c = int'(rdat);
      repeat (20) @(posedge ref_clk);
      rd(`PWM16_ADDR_COUNT);
      chk("stopped count", c, rdat);
    end
    $display("test flags done");
    setup(14, 1, 2, 2, 32'h100, 32'h10);
    c = 0;
    do begin
      rd(`PWM16_ADDR_COUNT);
      c++;
    end while (rdat < 32'h80 && c < 200);
    wr(`PWM16_ADDR_CAPTOP, 32'h10);
    rd(`PWM16_ADDR_CAPTOP);
    chk("capture top", 32'h10, rdat);
    repeat (300) @(posedge ref_clk);
    rd(`PWM16_ADDR_COUNT);
    chk("count past old top", 32'h1, 32'(rdat > 32'h100));
    $display("test capture top done");
    wrap_up();
  end
endmodule
